// ==== hdl/i2cs_ctrl_slave.v ====
// Purpose: Slave end of the two-wire serial control port of an audio amplifier.
// Assumes: User logic runs on sys_clk_i; bus pins are asynchronous to it.
// Notes:   Writes are handed out only as whole locations; reads are fetched again for every byte.
//
// Operation
// - Works as slave at 100 kHz and 400 kHz, single and multi-byte.
// - Slave only: never masters, never waits, never holds the clock low.
// - Subaddresses 0x00 to 0x1F accept single and multi-byte transfers.
// - Subaddresses 0x20 and up move only in whole four-byte words, and 0x29 to 0x36 only in whole five-word groups.
// - Multi-byte read sends bytes from the subaddress while master acknowledges.
// - Unused bits of narrow locations read back as zero.
// - Bytes are counted per location; short writes are dropped at stop or start.
// - Sequential write starts at the subaddress and advances through locations.
// - A partial final location is dropped; earlier complete locations are kept.
// - Write: start, address with zero, subaddress, data, all acknowledged, stop.
// - Every data byte of a multi-byte write is acknowledged.
// - Read: subaddress written, repeated start, address with one, acknowledge, data.
// - Bus address is latched from the strap pin once after reset.

`include "i2cs_defines.vh"

module i2cs_ctrl_slave (
	input  wire         sys_clk_i,
	input  wire         reset_n_i,
	input  wire         scl_i,
	input  wire         sda_i,
	output wire         sda_o,
	output wire         sda_oe_o,
	input  wire         adr_pin_i,
	output wire [6:0]   dev_addr_o,
	output wire         wr_stb_o,
	output wire [7:0]   wr_addr_o,
	output wire [159:0] wr_data_o,
	output wire         rd_req_o,
	output wire [7:0]   rd_addr_o,
	output wire [2:0]   rd_word_o,
	input  wire [31:0]  rd_data_i,
	input  wire [5:0]   rd_bits_i
);

	// ****************************************
	// States and helpers
	// ****************************************
	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_DEV  = 3'd1;
	localparam [2:0] ST_SUB  = 3'd2;
	localparam [2:0] ST_WDAT = 3'd3;
	localparam [2:0] ST_ACK  = 3'd4;
	localparam [2:0] ST_RD   = 3'd5;
	localparam [2:0] ST_MACK = 3'd6;

	function [2:0] last_word;
		input [7:0] sub;
		begin
			if (sub >= `I2CS_BQ_FIRST && sub <= `I2CS_BQ_LAST)
				last_word = `I2CS_BQ_WORD_END;
			else
				last_word = `I2CS_ONE_WORD;
		end
	endfunction

	function [1:0] last_byte;
		input [7:0] sub;
		begin
			if (sub <= `I2CS_LOW_TOP)
				last_byte = `I2CS_NARROW_BYTE;
			else
				last_byte = `I2CS_WIDE_BYTE;
		end
	endfunction

	function [31:0] bit_mask;
		input [5:0] bits;
		begin
			if (bits >= `I2CS_WORD_BITS)
				bit_mask = 32'hffffffff;
			else
				bit_mask = ~(32'hffffffff << bits);
		end
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	reg         scl_m_ff, scl_s_ff, scl_d_ff;
	reg         sda_m_ff, sda_s_ff, sda_d_ff;
	reg         adr_m_ff, adr_s_ff;
	reg [1:0]   strap_cnt_ff;
	reg         strap_done_ff;
	reg [6:0]   dev_addr_ff;
	reg [2:0]   state_ff;
	reg [2:0]   ack_next_ff;
	reg         flag_ff;
	reg [2:0]   bit_cnt_ff;
	reg [7:0]   shift_ff;
	reg [7:0]   tx_ff;
	reg         oe_ff;
	reg [7:0]   cur_addr_ff;
	reg [2:0]   word_ff;
	reg [1:0]   byte_ff;
	reg [`I2CS_BUF_MSB:0] wbuf_ff;
	reg         wr_stb_ff;
	reg [7:0]   wr_addr_ff;
	reg [`I2CS_BUF_MSB:0] wr_data_ff;
	reg         fetch_ff;
	reg         rd_req_ff;
	reg         cap_ff;
	reg [31:0]  rdw_ff;

	// ****************************************
	// Bus event decode
	// ****************************************
	wire scl_rise = scl_s_ff & ~scl_d_ff;
	wire scl_fall = ~scl_s_ff & scl_d_ff;
	wire bus_start = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
	wire bus_stop  = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
	wire [7:0] rx_byte = {shift_ff[6:0], sda_s_ff};
	wire end_byte = (byte_ff == last_byte(cur_addr_ff));
	wire end_loc  = end_byte && (word_ff == last_word(cur_addr_ff));
	wire [`I2CS_BUF_MSB:0] wbuf_nxt = {wbuf_ff[`I2CS_BUF_KEEP:0], rx_byte};

	// Narrow locations send their low byte; wide words go out high byte first.
	reg [7:0] rd_byte;
	always @* begin
		rd_byte = rdw_ff[7:0];
		if (last_byte(cur_addr_ff) == `I2CS_WIDE_BYTE) begin
			case (byte_ff)
				2'd0:    rd_byte = rdw_ff[31:24];
				2'd1:    rd_byte = rdw_ff[23:16];
				2'd2:    rd_byte = rdw_ff[15:8];
				default: rd_byte = rdw_ff[7:0];
			endcase
		end
	end

	// ****************************************
	// Synchronisers and strap capture
	// ****************************************
	// Sampling at 200 MHz leaves hundreds of cycles per bit at 400 kHz.
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scl_m_ff      <= 1'b1;
			scl_s_ff      <= 1'b1;
			scl_d_ff      <= 1'b1;
			sda_m_ff      <= 1'b1;
			sda_s_ff      <= 1'b1;
			sda_d_ff      <= 1'b1;
			adr_m_ff      <= 1'b0;
			adr_s_ff      <= 1'b0;
			strap_cnt_ff  <= 2'd0;
			strap_done_ff <= 1'b0;
			dev_addr_ff   <= `I2CS_ADDR_LO;
		end else begin
			scl_m_ff <= scl_i;
			scl_s_ff <= scl_m_ff;
			scl_d_ff <= scl_s_ff;
			sda_m_ff <= sda_i;
			sda_s_ff <= sda_m_ff;
			sda_d_ff <= sda_s_ff;
			adr_m_ff <= adr_pin_i;
			adr_s_ff <= adr_m_ff;
			// The pin is read once; afterwards it may serve as a fault output.
			if (!strap_done_ff) begin
				if (strap_cnt_ff == `I2CS_STRAP_WAIT) begin
					strap_done_ff <= 1'b1;
					dev_addr_ff   <= adr_s_ff ? `I2CS_ADDR_HI : `I2CS_ADDR_LO;
				end else begin
					strap_cnt_ff <= strap_cnt_ff + 2'd1;
				end
			end
		end
	end

	// ****************************************
	// Protocol engine
	// ****************************************
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff    <= ST_IDLE;
			ack_next_ff <= ST_IDLE;
			flag_ff     <= 1'b0;
			bit_cnt_ff  <= 3'd0;
			shift_ff    <= 8'h00;
			tx_ff       <= 8'h00;
			oe_ff       <= 1'b0;
			cur_addr_ff <= 8'h00;
			word_ff     <= 3'd0;
			byte_ff     <= 2'd0;
			wbuf_ff     <= {(`I2CS_BUF_MSB+1){1'b0}};
			wr_stb_ff   <= 1'b0;
			wr_addr_ff  <= 8'h00;
			wr_data_ff  <= {(`I2CS_BUF_MSB+1){1'b0}};
			fetch_ff    <= 1'b0;
			rd_req_ff   <= 1'b0;
			cap_ff      <= 1'b0;
			rdw_ff      <= 32'h00000000;
		end else begin
			wr_stb_ff <= 1'b0;
			fetch_ff  <= 1'b0;
			rd_req_ff <= fetch_ff;
			cap_ff    <= rd_req_ff;
			if (cap_ff)
				rdw_ff <= rd_data_i & bit_mask(rd_bits_i);
			if (!strap_done_ff) begin
				state_ff <= ST_IDLE;
			end else if (bus_start) begin
				// A start drops any unfinished location held in the buffer.
				state_ff   <= ST_DEV;
				bit_cnt_ff <= 3'd0;
				oe_ff      <= 1'b0;
				word_ff    <= 3'd0;
				byte_ff    <= 2'd0;
				wbuf_ff    <= {(`I2CS_BUF_MSB+1){1'b0}};
			end else if (bus_stop) begin
				state_ff <= ST_IDLE;
				oe_ff    <= 1'b0;
			end else begin
				case (state_ff)
					ST_DEV, ST_SUB, ST_WDAT: begin
						if (scl_rise) begin
							shift_ff   <= rx_byte;
							bit_cnt_ff <= bit_cnt_ff + 3'd1;
							if (bit_cnt_ff == `I2CS_BIT_LAST) begin
								state_ff <= ST_ACK;
								flag_ff  <= 1'b0;
								if (state_ff == ST_DEV) begin
									if (rx_byte[7:1] != dev_addr_ff) begin
										state_ff <= ST_IDLE;
									end else if (rx_byte[0]) begin
										ack_next_ff <= ST_RD;
										fetch_ff    <= 1'b1;
									end else begin
										ack_next_ff <= ST_SUB;
									end
								end else if (state_ff == ST_SUB) begin
									cur_addr_ff <= rx_byte;
									word_ff     <= 3'd0;
									byte_ff     <= 2'd0;
									ack_next_ff <= ST_WDAT;
								end else begin
									ack_next_ff <= ST_WDAT;
									if (end_loc) begin
										wr_stb_ff   <= 1'b1;
										wr_addr_ff  <= cur_addr_ff;
										wr_data_ff  <= wbuf_nxt;
										wbuf_ff     <= {(`I2CS_BUF_MSB+1){1'b0}};
										cur_addr_ff <= cur_addr_ff + 8'd1;
										word_ff     <= 3'd0;
										byte_ff     <= 2'd0;
									end else if (end_byte) begin
										wbuf_ff <= wbuf_nxt;
										word_ff <= word_ff + 3'd1;
										byte_ff <= 2'd0;
									end else begin
										wbuf_ff <= wbuf_nxt;
										byte_ff <= byte_ff + 2'd1;
									end
								end
							end
						end
					end
					ST_ACK: begin
						// SDA only moves while SCL is low; SCL itself is never driven.
						if (scl_fall) begin
							if (!flag_ff) begin
								oe_ff   <= 1'b1;
								flag_ff <= 1'b1;
							end else begin
								flag_ff    <= 1'b0;
								bit_cnt_ff <= 3'd0;
								state_ff   <= ack_next_ff;
								if (ack_next_ff == ST_RD) begin
									tx_ff <= rd_byte;
									oe_ff <= ~rd_byte[7];
								end else begin
									oe_ff <= 1'b0;
								end
							end
						end
					end
					ST_RD: begin
						if (scl_rise) begin
							bit_cnt_ff <= bit_cnt_ff + 3'd1;
							if (bit_cnt_ff == `I2CS_BIT_LAST) begin
								state_ff <= ST_MACK;
								flag_ff  <= 1'b0;
							end
						end else if (scl_fall) begin
							tx_ff <= {tx_ff[6:0], 1'b0};
							oe_ff <= ~tx_ff[6];
						end
					end
					ST_MACK: begin
						if (scl_fall) begin
							if (!flag_ff) begin
								oe_ff <= 1'b0;
							end else begin
								state_ff   <= ST_RD;
								bit_cnt_ff <= 3'd0;
								flag_ff    <= 1'b0;
								tx_ff      <= rd_byte;
								oe_ff      <= ~rd_byte[7];
							end
						end else if (scl_rise && !flag_ff) begin
							if (sda_s_ff) begin
								state_ff <= ST_IDLE;
							end else begin
								flag_ff  <= 1'b1;
								fetch_ff <= 1'b1;
								if (end_loc) begin
									cur_addr_ff <= cur_addr_ff + 8'd1;
									word_ff     <= 3'd0;
									byte_ff     <= 2'd0;
								end else if (end_byte) begin
									word_ff <= word_ff + 3'd1;
									byte_ff <= 2'd0;
								end else begin
									byte_ff <= byte_ff + 2'd1;
								end
							end
						end
					end
					default: begin
						state_ff <= ST_IDLE;
						oe_ff    <= 1'b0;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// The pin is open drain: it is only ever pulled low.
	assign sda_o      = 1'b0;
	assign sda_oe_o   = oe_ff;
	assign dev_addr_o = dev_addr_ff;
	assign wr_stb_o   = wr_stb_ff;
	assign wr_addr_o  = wr_addr_ff;
	assign wr_data_o  = wr_data_ff;
	assign rd_req_o   = rd_req_ff;
	assign rd_addr_o  = cur_addr_ff;
	assign rd_word_o  = word_ff;

endmodule // i2cs_ctrl_slave

// ==== hdl/i2cs_defines.vh ====
// Purpose: Constants for the two-wire control slave.
// Assumes: Included by the control slave module only.
// Notes:   Holds addresses, subaddress ranges and transfer lengths.
`ifndef I2CS_DEFINES_VH
`define I2CS_DEFINES_VH

// Bus addresses selected by the strap pin level.
`define I2CS_ADDR_LO     7'h1a
`define I2CS_ADDR_HI     7'h1b
// Highest subaddress that takes single bytes.
`define I2CS_LOW_TOP     8'h1f
// Filter-coefficient locations that hold five words.
`define I2CS_BQ_FIRST    8'h29
`define I2CS_BQ_LAST     8'h36
`define I2CS_BQ_WORD_END 3'd4
`define I2CS_ONE_WORD    3'd0
// Last byte index inside a wide word and inside a narrow location.
`define I2CS_WIDE_BYTE   2'd3
`define I2CS_NARROW_BYTE 2'd0
// Last bit index of a serial byte.
`define I2CS_BIT_LAST    3'd7
// Full width of a read word.
`define I2CS_WORD_BITS   6'd32
// Cycles after reset release before the strap is taken.
`define I2CS_STRAP_WAIT  2'd2
// Write buffer width: five words of thirty-two bits.
`define I2CS_BUF_MSB     159
`define I2CS_BUF_KEEP    151

`endif

// ==== test/i2cs_ctrl_slave_properties.sv ====
// Purpose: Port checks for the control slave.
// Assumes: One clock domain; bus pins pass a two-stage synchroniser.
// Notes:   Answers on the data pin trail a bus clock fall by a few cycles.
module i2cs_checker (
	input wire         sys_clk_i,
	input wire         reset_n_i,
	input wire         scl_i,
	input wire         sda_o,
	input wire         sda_oe_o,
	input wire [6:0]   dev_addr_o,
	input wire         wr_stb_o,
	input wire [7:0]   wr_addr_o,
	input wire [159:0] wr_data_o,
	input wire         rd_req_o,
	input wire [7:0]   rd_addr_o,
	input wire [2:0]   rd_word_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_fetch_held;
		##1 !rd_req_o && $stable(rd_addr_o) && $stable(rd_word_o);
	endsequence
	property p_open_drain;
		sda_o == 1'b0;
	endproperty
	property p_oe_time;
		$changed(sda_oe_o) |-> ($past(scl_i, 3) && !$past(scl_i, 2)) ||
			($past(scl_i, 4) && !$past(scl_i, 3)) || ($past(scl_i, 5) && !$past(scl_i, 4));
	endproperty
	property p_addr_val;
		dev_addr_o == 7'h1a || dev_addr_o == 7'h1b;
	endproperty
	property p_stb_pulse;
		wr_stb_o |=> !wr_stb_o;
	endproperty
	property p_narrow;
		wr_stb_o && wr_addr_o <= 8'h1f |-> wr_data_o[159:8] == 152'h0;
	endproperty
	property p_wide;
		wr_stb_o && (wr_addr_o < 8'h29 || wr_addr_o > 8'h36) |-> wr_data_o[159:32] == 128'h0;
	endproperty
	property p_fetch;
		rd_req_o |-> s_fetch_held;
	endproperty
	property p_word;
		rd_word_o <= 3'h4;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
	a_oe_time: assert property (p_oe_time) else $error("data pin moved off slot");
	a_addr_val: assert property (p_addr_val) else $error("bad bus address");
	a_stb_pulse: assert property (p_stb_pulse) else $error("strobe too long");
	a_narrow: assert property (p_narrow) else $error("narrow data too wide");
	a_wide: assert property (p_wide) else $error("word data too wide");
	a_fetch: assert property (p_fetch) else $error("fetch not held");
	a_word: assert property (p_word) else $error("word index out of range");
endmodule // i2cs_checker

bind i2cs_ctrl_slave i2cs_checker u_i2cs_checker (.sys_clk_i, .reset_n_i, .scl_i, .sda_o,
	.sda_oe_o, .dev_addr_o, .wr_stb_o, .wr_addr_o, .wr_data_o, .rd_req_o, .rd_addr_o,
	.rd_word_o);

// ==== test/i2cs_master_model.sv ====
// Purpose: Bus master model for the control slave.
// Assumes: The bench resolves the wire from both pull-down enables.
// Notes:   Phases of 64 ns, since the slave needs 8 cycles per half period.
module i2cs_master_model (
	output reg  scl_o,
	output reg  sda_oe_o,
	input  wire sda_i
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	task bit_io(input b, output r);
		#32 sda_oe_o = !b;
		#32 scl_o = 1'b1;
		#64 r = sda_i;
		scl_o = 1'b0;
	endtask
	task start;
		scl_o = 1'b0;
		#32 sda_oe_o = 1'b0;
		#32 scl_o = 1'b1;
		#64 sda_oe_o = 1'b1;
		#64 scl_o = 1'b0;
	endtask
	task stop;
		#32 sda_oe_o = 1'b1;
		#32 scl_o = 1'b1;
		#64 sda_oe_o = 1'b0;
		#64;
	endtask
	task wr_byte(input [7:0] d, output ack);
		integer i;
		reg     r;
		for (i = 7; i >= 0; i = i - 1)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task rd_byte(input last, output [7:0] d);
		integer i;
		reg     r;
		for (i = 7; i >= 0; i = i - 1) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule // i2cs_master_model

// ==== test/i2cs_ctrl_slave_tb.sv ====
// Purpose: Self-checking bench for the control slave.
// Assumes: The master model drives the bus; the bench answers fetches.
// Notes:   Seed 52 gives repeatable subaddresses, lengths and data.
module i2cs_ctrl_slave_tb;
	timeunit 1ns;
	timeprecision 100ps;
	reg          sys_clk_i = 1'b0;
	reg          reset_n_i = 1'b0;
	reg          adr_pin_i = 1'b1;
	reg  [31:0]  rd_data_i = 32'h0;
	reg  [5:0]   rd_bits_i = 6'h20;
	wire         scl_i, m_oe, sda_o, sda_oe_o, wr_stb_o, rd_req_o;
	wire         sda_i = !(m_oe || sda_oe_o);
	wire [6:0]   dev_addr_o;
	wire [7:0]   wr_addr_o, rd_addr_o;
	wire [159:0] wr_data_o;
	wire [2:0]   rd_word_o;
	integer      bad_count = 0, num_checks = 0, i, j, k;
	reg  [7:0]   q[$];
	reg  [167:0] got[$];
	reg  [159:0] e;
	reg  [7:0]   rb, sub;
	reg  [6:0]   dev;
	reg          ack;
	always #2.5 sys_clk_i = !sys_clk_i;
	i2cs_ctrl_slave u_i2cs_ctrl_slave (.sys_clk_i, .reset_n_i, .scl_i, .sda_i, .sda_o,
		.sda_oe_o, .adr_pin_i, .dev_addr_o, .wr_stb_o, .wr_addr_o, .wr_data_o, .rd_req_o,
		.rd_addr_o, .rd_word_o, .rd_data_i, .rd_bits_i);
	i2cs_master_model u_i2cs_master_model (.scl_o(scl_i), .sda_oe_o(m_oe), .sda_i);
	function [31:0] word_of(input [7:0] a);
		word_of = {a, ~a, 8'h3c, a ^ 8'h5a};
	endfunction
	// Odd word locations hold 24 bits, so their top byte must read as zero.
	function [5:0] bits_of(input [7:0] a);
		bits_of = (a > 8'h1f && a[0]) ? 6'h18 : 6'h20;
	endfunction
	function [7:0] exp_rd(input [7:0] s, input integer n);
		reg [7:0]  a;
		reg [31:0] w;
		a = (s <= 8'h1f) ? s + n[7:0] : s + n[9:2];
		w = word_of(a) & ~(32'hffffffff << bits_of(a));
		exp_rd = (s <= 8'h1f) ? w[7:0] : 8'(w >> (8 * (3 - n % 4)));
	endfunction
	always @(negedge sys_clk_i) begin
		rd_data_i <= word_of(rd_addr_o) ^ {29'h0, rd_word_o};
		rd_bits_i <= bits_of(rd_addr_o);
	end
	always @(posedge sys_clk_i)
		if (wr_stb_o === 1'b1)
			got.push_back({wr_addr_o, wr_data_o});
	task check(input [167:0] seen, input [167:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("ERROR %0t: saw %0h, want %0h", $time, seen, exp);
		end
	endtask
	task conclude;
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task do_reset(input pin);
		@(negedge sys_clk_i);
		reset_n_i = 1'b0;
		adr_pin_i = pin;
		dev = {6'h0d, pin};
		repeat (4) @(negedge sys_clk_i);
		reset_n_i = 1'b1;
		repeat (12) @(negedge sys_clk_i);
		check(dev_addr_o, dev);
	endtask
	task put(input [7:0] b, input want);
		u_i2cs_master_model.wr_byte(b, ack);
		check(ack, want);
	endtask
	task head(input [7:0] s);
		u_i2cs_master_model.start;
		put({dev, 1'b0}, 1'b1);
		put(s, 1'b1);
	endtask
	task wr_seq(input [7:0] s, input integer n);
		q.delete();
		head(s);
		for (i = 0; i < n; i = i + 1) begin
			q.push_back(8'($urandom));
			put(q[i], 1'b1);
		end
		u_i2cs_master_model.stop;
	endtask
	task expect_loc(input [7:0] a, input integer off, input integer n);
		e = 160'h0;
		for (i = off; i < off + n; i = i + 1)
			e = {e[151:0], q[i]};
		check(got.pop_front(), {a, e});
	endtask
	task rd_seq(input [7:0] s, input integer n);
		head(s);
		u_i2cs_master_model.start;
		put({dev, 1'b1}, 1'b1);
		for (i = 0; i < n; i = i + 1) begin
			u_i2cs_master_model.rd_byte(i == n - 1, rb);
			check(rb, exp_rd(s, i));
		end
		u_i2cs_master_model.stop;
	endtask
	initial begin
		i = $urandom(52);
		do_reset(1'b1);
		sub = 8'($urandom % 27);
		j = 1 + $urandom % 4;
		wr_seq(sub, j);
		check(got.size(), j);
		for (k = 0; k < j; k = k + 1)
			expect_loc(sub + k[7:0], k, 1);
		wr_seq(8'h1e, 3);
		check(got.size(), 2);
		expect_loc(8'h1e, 0, 1);
		expect_loc(8'h1f, 1, 1);
		wr_seq(8'h22, 6);
		check(got.size(), 1);
		expect_loc(8'h22, 0, 4);
		for (j = 19; j <= 20; j = j + 1) begin
			wr_seq(8'h29, j);
			check(got.size(), j - 19);
		end
		expect_loc(8'h29, 0, 20);
		u_i2cs_master_model.start;
		put({dev ^ 7'h01, 1'b0}, 1'b0);
		put(sub, 1'b0);
		u_i2cs_master_model.stop;
		do_reset(1'b0);
		rd_seq(sub, 3);
		rd_seq(8'h24, 8);
		check(got.size(), 0);
		conclude;
	end
	initial begin
		#400000;
		bad_count = bad_count + 1;
		conclude;
	end
endmodule // i2cs_ctrl_slave_tb
